//--- rtl/olp_list_pointer_regs.sv
// Purpose: Periodic and control-list descriptor pointer registers
// Assumes: Traversal engine pulses update strobes; driver reads by word offset
// Notes:   Pointers are read-only to the register port apart from driver loads of current
`timescale 1ns/1ps
module olp_list_pointer_regs #(
    parameter int DATA_W = 32,
    parameter int OFS_W  = 8
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  soft_rst_i,
    input  wire logic                  reg_rd_i,
    input  wire logic                  reg_wr_i,
    input  wire logic [OFS_W-1:0]      reg_addr_i,
    input  wire logic [DATA_W-1:0]     reg_wdata_i,
    input  wire logic                  control_enable_i,
    input  wire logic [DATA_W-1:0]     comm_base_i,
    input  wire olp_pkg::olp_ptr_upd_s periodic_upd_i,
    input  wire olp_pkg::olp_ptr_upd_s control_head_upd_i,
    input  wire olp_pkg::olp_ptr_upd_s control_adv_i,
    input  wire logic                  control_list_end_i,
    input  wire logic                  control_list_filled_i,
    output logic [DATA_W-1:0]          reg_rdata_o,
    output logic                       reg_rvalid_o,
    output logic                       control_list_filled_clr_o,
    output logic [DATA_W-1:0]          periodic_current_addr_o,
    output logic [DATA_W-1:0]          control_head_addr_o,
    output logic [DATA_W-1:0]          control_current_addr_o,
    output logic [DATA_W-1:0]          comm_base_o
);
    // ------------------------------------------------------------
    // Local constants
    // ------------------------------------------------------------
    // Low address bits that no descriptor pointer keeps
    localparam int PTR_LSB  = olp_pkg::ADDR_LSB;
    // Low address bits that the communication-area base drops
    localparam int BASE_LSB = olp_pkg::COMM_LSB;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Clears the reserved low bits of a descriptor address
    function automatic logic [DATA_W-1:0] align_ptr(input logic [DATA_W-1:0] a);
        align_ptr = {a[DATA_W-1:PTR_LSB], {PTR_LSB{1'b0}}};
    endfunction

    // Clears the low byte of the communication-area base
    function automatic logic [DATA_W-1:0] align_base(input logic [DATA_W-1:0] a);
        align_base = {a[DATA_W-1:BASE_LSB], {BASE_LSB{1'b0}}};
    endfunction

    // ------------------------------------------------------------
    // Register-port decode
    // ------------------------------------------------------------
    // One hit per mapped offset; any other offset hits nothing
    logic hit_periodic;
    logic hit_head;
    logic hit_current;
    logic drv_cur_wr;

    always_comb begin
        hit_periodic = (reg_addr_i == olp_pkg::PERIODIC_CUR_OFS);
        hit_head     = (reg_addr_i == olp_pkg::CONTROL_HEAD_OFS);
        hit_current  = (reg_addr_i == olp_pkg::CONTROL_CUR_OFS);
        // The driver may only move the current pointer while the list is disabled
        drv_cur_wr   = reg_wr_i && hit_current && !control_enable_i;
    end

    // ------------------------------------------------------------
    // Periodic current-descriptor pointer
    // ------------------------------------------------------------
    // Read-only to the driver; only the engine and resets move it
    logic [DATA_W-1:0] pcur_q;
    logic [DATA_W-1:0] pcur_d;

    always_comb begin
        pcur_d = pcur_q;
        if (soft_rst_i) begin
            pcur_d = olp_pkg::PTR_RESET;
        end else if (periodic_upd_i.load) begin
            // Engine reports each periodic descriptor as it finishes with it
            pcur_d = align_ptr(periodic_upd_i.addr);
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pcur_q <= olp_pkg::PTR_RESET;
        end else begin
            pcur_q <= pcur_d;
        end
    end

    // ------------------------------------------------------------
    // Control-list head pointer
    // ------------------------------------------------------------
    // Read-only to the driver; filled in by the engine at start-up
    logic [DATA_W-1:0] chead_q;
    logic [DATA_W-1:0] chead_d;

    always_comb begin
        chead_d = chead_q;
        if (soft_rst_i) begin
            chead_d = olp_pkg::PTR_RESET;
        end else if (control_head_upd_i.load) begin
            // Loaded from the communication area while the controller initialises
            chead_d = align_ptr(control_head_upd_i.addr);
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chead_q <= olp_pkg::PTR_RESET;
        end else begin
            chead_q <= chead_d;
        end
    end

    // ------------------------------------------------------------
    // Control-list current pointer and filled-flag clear
    // ------------------------------------------------------------
    // Priority: soft reset, list end, engine advance, driver write
    logic [DATA_W-1:0] ccur_q;
    logic [DATA_W-1:0] ccur_d;
    logic              clr_q;
    logic              clr_d;

    always_comb begin
        ccur_d = ccur_q;
        clr_d  = 1'b0;
        if (soft_rst_i) begin
            // Soft reset wins over every load and leaves the filled flag alone
            ccur_d = olp_pkg::PTR_RESET;
        end else if (control_list_end_i) begin
            // Only a filled list wraps; an advance in the same cycle is dropped
            if (control_list_filled_i) begin
                ccur_d = chead_q;
                clr_d  = 1'b1;
            end
        end else if (control_adv_i.load) begin
            // Held across frames, so the next frame resumes where this one stopped
            ccur_d = align_ptr(control_adv_i.addr);
        end else if (drv_cur_wr) begin
            ccur_d = align_ptr(reg_wdata_i);
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // Zero marks an empty control list until the engine or driver loads it
            ccur_q <= olp_pkg::PTR_RESET;
            clr_q  <= 1'b0;
        end else begin
            ccur_q <= ccur_d;
            clr_q  <= clr_d;
        end
    end

    // ------------------------------------------------------------
    // Communication-area base copy
    // ------------------------------------------------------------
    // The base register itself lives outside; this is its aligned image
    logic [DATA_W-1:0] comm_q;
    logic [DATA_W-1:0] comm_d;

    always_comb begin
        // Whatever the driver wrote, the low byte never survives
        comm_d = align_base(comm_base_i);
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            comm_q <= olp_pkg::BASE_RESET;
        end else begin
            comm_q <= comm_d;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Answer one cycle after the strobe; idle data is zero
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              rvalid_q;
    logic              rvalid_d;

    always_comb begin
        rvalid_d = reg_rd_i;
        rdata_d  = olp_pkg::RDATA_IDLE;
        // Reads return each pointer as it stands, so an engine update in the strobe cycle shows only on a later read
        if (reg_rd_i) begin
            if (hit_periodic) begin
                rdata_d = pcur_q;
            end else if (hit_head) begin
                rdata_d = chead_q;
            end else if (hit_current) begin
                rdata_d = ccur_q;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q  <= olp_pkg::RDATA_IDLE;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a register, so nothing combinational leaves the bank
    assign reg_rdata_o               = rdata_q;
    assign reg_rvalid_o              = rvalid_q;
    assign control_list_filled_clr_o = clr_q;
    assign periodic_current_addr_o   = pcur_q;
    assign control_head_addr_o       = chead_q;
    assign control_current_addr_o    = ccur_q;
    assign comm_base_o               = comm_q;
endmodule

//--- rtl/olp_pkg.sv
// Purpose: Constants and carriers for the list-pointer register bank
// Assumes: 32-bit register data, word offsets from the controller base address
// Notes:   Pointers, read data and the base copy share one word width
package olp_pkg;
    localparam logic [7:0]  PERIODIC_CUR_OFS = 8'h1c;
    localparam logic [7:0]  CONTROL_HEAD_OFS = 8'h20;
    localparam logic [7:0]  CONTROL_CUR_OFS  = 8'h24;
    localparam int          ADDR_LSB         = 4;
    localparam int          COMM_LSB         = 8;
    localparam int          FILLED_FLAG_BIT  = 1;
    localparam int          LIST_ENABLE_BIT  = 4;
    localparam logic [31:0] PTR_RESET        = 32'h0000_0000;
    localparam logic [31:0] BASE_RESET       = 32'h0000_0000;
    localparam logic [31:0] RDATA_IDLE       = 32'h0000_0000;

    typedef struct packed {
        logic        load;
        logic [31:0] addr;
    } olp_ptr_upd_s;
endpackage

//--- tb/olp_flag_model.sv
// Purpose: Filled flag of the command status
// Assumes: Set by the driver side, cleared by the bank's clear pulse
// Notes:   A clear and a set in one cycle leave the flag clear
`timescale 1ns/1ps
module olp_flag_model (
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
        if (sys_rst_i) flag_o <= 1'b0;
        else if (clr_i) flag_o <= 1'b0;
        else if (set_i) flag_o <= 1'b1;
endmodule

//--- tb/olp_list_pointer_regs_bench.sv
// Purpose: Register-port and engine-side tests of the list-pointer bank
// Assumes: Filled flag comes from the partner model; one clock
// Notes:   Tests are rd and wr calls with expected values
`timescale 1ns/1ps
module olp_list_pointer_regs_bench;
    logic ref_clk_i = 0, sys_rst_i = 1, soft_rst_i = 0, reg_rd_i = 0, reg_wr_i = 0, control_enable_i = 0;
    logic control_list_end_i = 0, set_flag = 0, control_list_filled_i, reg_rvalid_o, control_list_filled_clr_o;
    logic [7:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, comm_base_i = 32'hffff_ffff, reg_rdata_o, periodic_current_addr_o;
    logic [31:0] control_head_addr_o, control_current_addr_o, comm_base_o;
    olp_pkg::olp_ptr_upd_s periodic_upd_i = '0, control_head_upd_i = '0, control_adv_i = '0;
    int n_mismatch = 0, checks = 0;
    olp_list_pointer_regs olp_list_pointer_regs_inst (.*);
    olp_flag_model olp_flag_model_inst (.ref_clk_i, .sys_rst_i, .set_i(set_flag),
        .clr_i(control_list_filled_clr_o), .flag_o(control_list_filled_i));
    initial forever #2 ref_clk_i = ~ref_clk_i;
    task automatic cmp(logic [32:0] got, logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge ref_clk_i) reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge ref_clk_i) reg_rd_i <= 0;
        #1 cmp({reg_rvalid_o, reg_rdata_o}, {1'b1, e});
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk_i) reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i) reg_wr_i <= 0;
    endtask
    task automatic test_done;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Tests need about 55 cycles; 5000 cycles leaves ample margin
    initial begin
        #20000;
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done;
    end
    initial begin
        // ------------------------------------------------------------
        // Reset values, unmapped offset and aligned base copy
        // ------------------------------------------------------------
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd(8'h24, 32'h0000_0000);
        rd(8'h1c, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        rd(8'h28, 32'h0000_0000);
        cmp({1'b0, comm_base_o}, {1'b0, 32'hffff_ff00});
        $display("test reset values done");
        // ------------------------------------------------------------
        // Engine loads and refused driver writes
        // ------------------------------------------------------------
        @(posedge ref_clk_i) periodic_upd_i <= '{1'b1, 32'h1234_567f};
        @(posedge ref_clk_i) control_head_upd_i <= '{1'b1, 32'habcd_ef0f};
        periodic_upd_i <= '0;
        @(posedge ref_clk_i) control_head_upd_i <= '0;
        wr(8'h1c, 32'h5555_5550);
        wr(8'h20, 32'h6666_6660);
        rd(8'h1c, 32'h1234_5670);
        rd(8'h20, 32'habcd_ef00);
        cmp({1'b0, periodic_current_addr_o}, {1'b0, 32'h1234_5670});
        cmp({1'b0, control_head_addr_o}, {1'b0, 32'habcd_ef00});
        $display("test engine loads done");
        // ------------------------------------------------------------
        // Driver write of the current pointer
        // ------------------------------------------------------------
        @(posedge ref_clk_i) control_enable_i <= 1'b1;
        wr(8'h24, 32'h7777_7770);
        rd(8'h24, 32'h0000_0000);
        @(posedge ref_clk_i) control_enable_i <= 1'b0;
        wr(8'h24, 32'h7777_777f);
        rd(8'h24, 32'h7777_7770);
        cmp({1'b0, control_current_addr_o}, {1'b0, 32'h7777_7770});
        $display("test driver write done");
        // ------------------------------------------------------------
        // Advance and list-end wrap
        // ------------------------------------------------------------
        @(posedge ref_clk_i) control_adv_i <= '{1'b1, 32'h2222_2220};
        @(posedge ref_clk_i) control_adv_i <= '0;
        control_list_end_i <= 1'b1;
        @(posedge ref_clk_i) control_list_end_i <= 1'b0;
        rd(8'h24, 32'h2222_2220);
        @(posedge ref_clk_i) set_flag <= 1'b1;
        @(posedge ref_clk_i) set_flag <= 1'b0;
        control_list_end_i <= 1'b1;
        @(posedge ref_clk_i) control_list_end_i <= 1'b0;
        rd(8'h24, 32'habcd_ef00);
        cmp({32'h0000_0000, control_list_filled_i}, 33'h0_0000_0000);
        $display("test list wrap done");
        // ------------------------------------------------------------
        // Soft reset
        // ------------------------------------------------------------
        @(posedge ref_clk_i) soft_rst_i <= 1'b1;
        @(posedge ref_clk_i) soft_rst_i <= 1'b0;
        rd(8'h1c, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        rd(8'h24, 32'h0000_0000);
        $display("test soft reset done");
        test_done;
    end
endmodule

//--- tb/olp_list_pointer_regs_monitor.sv
// Purpose: Port checks
// Assumes: One clock
// Notes:   Bound to olp_list_pointer_regs
`timescale 1ns/1ps
module olp_list_pointer_regs_monitor (
    input wire logic                  ref_clk_i,
    input wire logic                  sys_rst_i,
    input wire logic                  soft_rst_i,
    input wire logic                  reg_rd_i,
    input wire logic                  reg_rvalid_o,
    input wire logic                  control_list_end_i,
    input wire logic                  control_list_filled_i,
    input wire logic                  control_list_filled_clr_o,
    input wire logic [31:0]           control_head_addr_o,
    input wire logic [31:0]           control_current_addr_o,
    input wire logic [31:0]           periodic_current_addr_o,
    input wire logic [31:0]           comm_base_o,
    input wire olp_pkg::olp_ptr_upd_s periodic_upd_i
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no answer");
    list_wrap_a: assert property (control_list_end_i && control_list_filled_i && !soft_rst_i |=>
        control_list_filled_clr_o && control_current_addr_o == $past(control_head_addr_o)) else $error("no wrap");
    clear_cause_a: assert property (control_list_filled_clr_o |-> $past(control_list_end_i)) else $error("clear");
    end_idle_a: assert property (control_list_end_i && !control_list_filled_i && !soft_rst_i |=>
        $stable(control_current_addr_o)) else $error("end moved");
    soft_zero_a: assert property (soft_rst_i |=> (periodic_current_addr_o | control_head_addr_o
        | control_current_addr_o) == 32'h0) else $error("soft reset");
    low_zero_a: assert property (((periodic_current_addr_o | control_head_addr_o
        | control_current_addr_o) & 32'hf) == 32'h0) else $error("low bits");
    comm_align_a: assert property (comm_base_o[7:0] == 8'h00) else $error("align");
    period_load_a: assert property (periodic_upd_i.load && !soft_rst_i |=>
        periodic_current_addr_o == {$past(periodic_upd_i.addr[31:4]), 4'h0}) else $error("periodic");
endmodule
bind olp_list_pointer_regs olp_list_pointer_regs_monitor olp_list_pointer_regs_monitor_inst (.*);
